// ### uvm_pkg_ctl.sv
// Purpose: shared constants and types for the memory mode controller (host side)
// Assumes: 100 MHz clock, one clock domain
// Notes: timing counts derive from printed times and the clock period
package uvmc_pkg;
   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_PS = 10000;
   localparam int unsigned SETUP_TIME_NS = 2000;     // supply, select, address, data setup
   localparam int unsigned PULSE_TIME_NS = 100000;   // nominal program pulse
   localparam int unsigned ACCESS_TIME_NS = 200;     // slowest address/select access
   localparam int unsigned GATE_TIME_NS = 150;       // data valid from gate in verify
   localparam int unsigned FLOAT_TIME_NS = 130;      // gate high to float
   localparam int unsigned SETUP_CYC = (SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PULSE_CYC = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned ACCESS_CYC = (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned GATE_CYC = (GATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FLOAT_CYC = (FLOAT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned MAX_TRIES = 25;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 14;
   localparam int unsigned TRY_W = 5;
   localparam logic [16:0] ADDR_RESET = 17'h00000;
   localparam int unsigned ID_TRIGGER_BIT = 9;
   localparam int unsigned CODE_SELECT_BIT = 0;

   // ***************************************************************
   // commands and pin bundle
   // ***************************************************************
   typedef enum logic [1:0] {CMD_READ, CMD_PROGRAM, CMD_IDENT} uvmc_cmd_t;

   typedef struct packed {
      logic chip_select_n;
      logic output_gate_n;
      logic program_strobe_n;
      logic program_supply_on;
      logic raised_core_supply;
      logic identifier_high_voltage;
   } uvmc_ctl_t;

   localparam uvmc_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
endpackage : uvmc_pkg

// ### uvmc_timer.sv
// Purpose: down-counting wait timer used for every phase delay
// Assumes: load and count in the same clock domain
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module uvmc_timer
   import uvmc_pkg::*;
#(
   parameter int unsigned WIDTH = CNT_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic done
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   // ***************************************************************
   // next count
   // ***************************************************************
   always_comb begin
      next_count = count;
      if (load) begin
         next_count = load_value;
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
   end

   // register count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign done = (count == '0);
endmodule : uvmc_timer

// ### uvmc_ctrl.sv
// Purpose: host controller that reads, programs and identifies the memory through its pins
// Assumes: supplies switched by external regulators from the supply enable outputs
// Notes: one request at a time; busy is high from acceptance until done
//
// Notes on behaviour
// - program mode needs high program supply and byte on data pins
// - strobe low pulse with select low, gate high writes the byte
// - verify uses select low, strobe high, gate low, raised core supply
// - read back and compare each byte after programming it
// - select high under program supply ignores the strobe
// - identifier needs high voltage on trigger line, others low; code select picks code
// - select from address decode, gate from system read strobe; here the controller's own read sequence drives both
// - strobe low pulse lasts the nominal pulse width
// - verify after each pulse, retry on mismatch, fail after maximum tries
`timescale 1ns/1ps
module uvmc_ctrl
   import uvmc_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYC,
   parameter int unsigned TRIES = MAX_TRIES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire uvmc_cmd_t req_cmd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic req_code_select,
   output logic busy,
   output logic done,
   output logic fail,
   output logic [DATA_W-1:0] rdata,
   output logic [ADDR_W-1:0] mem_addr,
   output uvmc_ctl_t mem_ctl,
   output logic [DATA_W-1:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic [DATA_W-1:0] mem_data_in
);
   // refuse pulse or try counts that the timer or the try counter cannot hold
   if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CNT_W) ||
       TRIES < 1 || TRIES >= (1 << TRY_W)) begin : g_param_check
      $error("uvmc_ctrl: parameter out of range");
   end

   typedef enum logic [3:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_SAMPLE, ST_PULSE, ST_GAP, ST_VERIFY,
                             ST_CHECK, ST_FLOAT} uvmc_state_t;

   // ***************************************************************
   // input synchroniser for memory data pins
   // ***************************************************************
   logic [DATA_W-1:0] data_meta;
   logic [DATA_W-1:0] data_sync;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         data_meta <= mem_data_in;
         data_sync <= data_meta;
      end
   end

   // ***************************************************************
   // main state
   // ***************************************************************
   uvmc_state_t state, next_state;
   uvmc_cmd_t cmd, next_cmd;
   logic [TRY_W-1:0] tries, next_tries;
   logic next_busy, next_done, next_fail;
   logic [DATA_W-1:0] next_rdata, wbyte, next_wbyte;
   logic [ADDR_W-1:0] next_mem_addr;
   uvmc_ctl_t next_mem_ctl;
   logic [DATA_W-1:0] next_mem_data_out;
   logic next_mem_data_oe;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_value;
   logic tmr_done;

   uvmc_timer #(.WIDTH(CNT_W)) u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .load(tmr_load),
      .load_value(tmr_value),
      .done(tmr_done)
   );

   // next values for sequencing and pins
   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_tries = tries;
      next_busy = busy;
      next_done = 1'b0;
      next_fail = fail;
      next_rdata = rdata;
      next_wbyte = wbyte;
      next_mem_addr = mem_addr;
      next_mem_ctl = mem_ctl;
      next_mem_data_out = mem_data_out;
      next_mem_data_oe = mem_data_oe;
      tmr_load = 1'b0;
      tmr_value = '0;
      unique case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_busy = 1'b1;
               next_fail = 1'b0;
               next_cmd = req_cmd;
               next_wbyte = req_wdata;
               next_tries = '0;
               next_mem_addr = req_addr;
               next_mem_ctl = CTL_IDLE;
               if (req_cmd == CMD_PROGRAM) begin
                  next_mem_ctl.raised_core_supply = 1'b1;
                  next_mem_ctl.program_supply_on = 1'b1;
                  next_mem_data_out = req_wdata;
                  next_mem_data_oe = 1'b1;
               end else if (req_cmd == CMD_IDENT) begin
                  next_mem_addr = '0;
                  next_mem_addr[CODE_SELECT_BIT] = req_code_select;
                  next_mem_ctl.identifier_high_voltage = 1'b1;
               end
               tmr_load = 1'b1;
               tmr_value = CNT_W'(SETUP_CYC);
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               next_mem_ctl.chip_select_n = 1'b0;
               if (cmd == CMD_PROGRAM) begin
                  tmr_value = CNT_W'(SETUP_CYC);
                  next_state = ST_GAP;
               end else begin
                  next_mem_ctl.output_gate_n = 1'b0;
                  tmr_value = CNT_W'(ACCESS_CYC);
                  next_state = ST_ACCESS;
               end
               tmr_load = 1'b1;
            end
         end
         ST_ACCESS: begin
            if (tmr_done) begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            next_rdata = data_sync;
            next_mem_ctl.output_gate_n = 1'b1;
            next_mem_ctl.chip_select_n = 1'b1;
            tmr_load = 1'b1;
            tmr_value = CNT_W'(FLOAT_CYC);
            next_state = ST_FLOAT;
         end
         ST_GAP: begin
            // gate high, outputs floated, data driven and set up, then strobe
            if (tmr_done && !mem_data_oe) begin
               next_mem_data_oe = 1'b1;
               tmr_load = 1'b1;
               tmr_value = CNT_W'(SETUP_CYC);
            end else if (tmr_done) begin
               next_mem_ctl.program_strobe_n = 1'b0;
               tmr_load = 1'b1;
               // the strobe rises on the edge after done shows zero, so load one less for an exact width
               tmr_value = CNT_W'(PULSE_CYCLES - 1);
               next_tries = tries + 1'b1;
               next_state = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (tmr_done) begin
               next_mem_ctl.program_strobe_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = CNT_W'(SETUP_CYC);
               next_state = ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            // data hold time, then release the bus and open the gate for readback
            if (tmr_done) begin
               next_mem_data_oe = 1'b0;
               next_mem_ctl.output_gate_n = 1'b0;
               tmr_load = 1'b1;
               tmr_value = CNT_W'(GATE_CYC + 2);
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (tmr_done) begin
               next_rdata = data_sync;
               next_mem_ctl.output_gate_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = CNT_W'(FLOAT_CYC);
               if (data_sync == wbyte) begin
                  next_mem_ctl.chip_select_n = 1'b1;
                  next_state = ST_FLOAT;
               end else if (tries >= TRY_W'(TRIES)) begin
                  next_fail = 1'b1;
                  next_mem_ctl.chip_select_n = 1'b1;
                  next_state = ST_FLOAT;
               end else begin
                  // retry: let the memory outputs float before driving the byte again
                  next_state = ST_GAP;
               end
            end
         end
         ST_FLOAT: begin
            // drop supplies together after outputs float
            if (tmr_done) begin
               next_mem_ctl = CTL_IDLE;
               next_mem_data_oe = 1'b0;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // register controller state and pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cmd <= CMD_READ;
         tries <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         rdata <= '0;
         wbyte <= '0;
         mem_addr <= ADDR_RESET;
         mem_ctl <= CTL_IDLE;
         mem_data_out <= '0;
         mem_data_oe <= 1'b0;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         tries <= next_tries;
         busy <= next_busy;
         done <= next_done;
         fail <= next_fail;
         rdata <= next_rdata;
         wbyte <= next_wbyte;
         mem_addr <= next_mem_addr;
         mem_ctl <= next_mem_ctl;
         mem_data_out <= next_mem_data_out;
         mem_data_oe <= next_mem_data_oe;
      end
   end
endmodule : uvmc_ctrl

// ### uvmc_ctrl_sva.sv
// Purpose: pin protocol checks on the mode controller
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module uvmc_ctrl_sva
   import uvmc_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic busy,
   input wire logic done,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire uvmc_ctl_t mem_ctl,
   input wire logic mem_data_oe
);
   // ***************************************************************
   // helper counter and checks
   // ***************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] next_low_cnt;
   // counts cycles of the strobe held low
   always_comb next_low_cnt = mem_ctl.program_strobe_n ? '0 : low_cnt + 1'b1;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) low_cnt <= '0;
      else low_cnt <= next_low_cnt;
   end
   sequence s_take;
      req_valid && !busy;
   endsequence
   sequence s_pulse_end;
      $rose(mem_ctl.program_strobe_n);
   endsequence
   a_take_busy: assert property (s_take |=> busy) else $error("request not taken");
   a_busy_end: assert property ($fell(busy) |-> done) else $error("busy fell without done");
   a_done_single: assert property (done |=> !done) else $error("done longer than a cycle");
   a_idle_pins: assert property (!busy |-> mem_ctl == CTL_IDLE && !mem_data_oe)
      else $error("pins not idle");
   a_strobe_mode: assert property (!mem_ctl.program_strobe_n |-> !mem_ctl.chip_select_n
      && mem_ctl.output_gate_n && mem_ctl.program_supply_on && mem_data_oe) else $error("strobe outside program");
   a_no_clash: assert property (mem_data_oe |-> mem_ctl.output_gate_n) else $error("data drive clash");
   a_verify_mode: assert property (!mem_ctl.output_gate_n && mem_ctl.program_supply_on
      |-> mem_ctl.program_strobe_n && mem_ctl.raised_core_supply) else $error("bad verify pins");
   a_ident_addr: assert property (mem_ctl.identifier_high_voltage && !mem_ctl.chip_select_n
      |-> mem_addr[ADDR_W-1:1] == '0 && !mem_ctl.program_supply_on) else $error("bad identifier pins");
   a_strobe_width: assert property (s_pulse_end |-> low_cnt >= PULSE_CYCLES * 19 / 20
      && low_cnt <= PULSE_CYCLES * 21 / 20) else $error("strobe width off");
   a_data_hold: assert property (s_pulse_end |-> mem_data_oe) else $error("data released at strobe end");
   a_verify_follow: assert property (s_pulse_end |-> ##[1:300] !mem_ctl.output_gate_n)
      else $error("no verify after pulse");
endmodule : uvmc_ctrl_sva

// ### uvmc_mem_model.sv
// Purpose: behavioural model of the memory on the controller pins
// Assumes: pins resolved by the testbench
// Notes: unwritten cells read as erased
`timescale 1ns/1ps
module uvmc_mem_model
   import uvmc_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hc3, // arbitrary value
   parameter int ACC_NS = 120
) (
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire uvmc_ctl_t mem_ctl,
   input wire logic [DATA_W-1:0] pins,
   output logic [DATA_W-1:0] model_pins
);
   // ***************************************************************
   // cells, write and read
   // ***************************************************************
   logic [DATA_W-1:0] cells [int];
   logic [DATA_W-1:0] q = 8'h00;
   wire id_mode = mem_ctl.identifier_high_voltage && mem_addr[ADDR_W-1:1] == '0;
   assign model_pins = q;
   // write at the end of the strobe pulse, bits only cleared
   always @(posedge mem_ctl.program_strobe_n) begin
      if (!mem_ctl.chip_select_n && mem_ctl.output_gate_n && mem_ctl.program_supply_on) begin
         cells[mem_addr] = (cells.exists(mem_addr) ? cells[mem_addr] : 8'hff) & pins;
      end
   end
   // drive only when selected and gated, else a changing value
   always @(mem_addr, mem_ctl) begin
      if (!mem_ctl.chip_select_n && !mem_ctl.output_gate_n) begin
         q <= #ACC_NS id_mode ? (mem_addr[0] ? PART_CODE : MAKER_CODE)
            : (cells.exists(mem_addr) ? cells[mem_addr] : 8'hff);
      end else begin
         q <= ~q;
      end
   end
endmodule : uvmc_mem_model

// ### testbench.sv
// Purpose: self-checking bench for the mode controller
// Assumes: memory model on the pins, short pulse count
// Notes: table rows first, then reset and refusal cases
`timescale 1ns/1ps
module testbench
   import uvmc_pkg::*;
;
   // ***************************************************************
   // signals, instances and tasks
   // ***************************************************************
   typedef struct packed {
      uvmc_cmd_t cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic csel;
      logic [DATA_W-1:0] exp_rdata;
      logic exp_fail;
   } uvmc_row_t;
   localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
   localparam logic [7:0] PART = 8'hc3; // arbitrary value
   localparam uvmc_row_t ROWS [10] = '{
      '{CMD_IDENT, 17'h00000, 8'h00, 1'b0, MAKER, 1'b0},
      '{CMD_IDENT, 17'h1fffe, 8'h00, 1'b1, PART, 1'b0},
      '{CMD_READ, 17'h1ffff, 8'h00, 1'b0, 8'hff, 1'b0},
      '{CMD_PROGRAM, 17'h00005, 8'ha5, 1'b0, 8'ha5, 1'b0},
      '{CMD_READ, 17'h00005, 8'h00, 1'b0, 8'ha5, 1'b0},
      '{CMD_READ, 17'h10005, 8'h00, 1'b0, 8'hff, 1'b0},
      '{CMD_PROGRAM, 17'h00005, 8'hf0, 1'b0, 8'ha0, 1'b1},
      '{CMD_READ, 17'h00005, 8'h00, 1'b0, 8'ha0, 1'b0},
      '{CMD_PROGRAM, 17'h10005, 8'h3c, 1'b0, 8'h3c, 1'b0},
      '{CMD_READ, 17'h10005, 8'h00, 1'b0, 8'h3c, 1'b0}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   uvmc_cmd_t req_cmd = CMD_READ;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic req_code_select = 1'b0;
   logic busy, done, fail, mem_data_oe;
   logic [DATA_W-1:0] rdata, mem_data_out, model_pins;
   logic [ADDR_W-1:0] mem_addr;
   uvmc_ctl_t mem_ctl;
   wire logic [DATA_W-1:0] pins = mem_data_oe ? mem_data_out : model_pins;
   int miscompares = 0;
   int checks = 0;
   always #5 clk = ~clk;
   uvmc_ctrl #(.PULSE_CYCLES(20), .TRIES(3)) u_uvmc_ctrl (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_code_select(req_code_select),
      .busy(busy), .done(done), .fail(fail), .rdata(rdata), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(pins));
   uvmc_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_uvmc_mem_model (.mem_addr(mem_addr),
      .mem_ctl(mem_ctl), .pins(pins), .model_pins(model_pins));
   task automatic compare(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : compare
   // present one request for one edge, called just after an edge
   task automatic start(input uvmc_row_t r);
      req_cmd = r.cmd;
      req_addr = r.addr;
      req_wdata = r.wdata;
      req_code_select = r.csel;
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
   endtask : start
   task automatic finish(input uvmc_row_t r);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 20000) miscompares++;
      compare("rdata", r.exp_rdata, rdata);
      compare("fail", {7'h00, r.exp_fail}, {7'h00, fail});
   endtask : finish
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   // table rows, then reset in mid-program and a refused request
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      for (int i = 0; i < 10; i++) begin
         start(ROWS[i]);
         finish(ROWS[i]);
         $display("row %0d done", i);
      end
      start('{CMD_PROGRAM, 17'h00003, 8'h00, 1'b0, 8'hff, 1'b0});
      repeat (300) @(posedge clk);
      #1;
      rst_b = 1'b0;
      #1;
      compare("ctl", {2'b00, CTL_IDLE}, {2'b00, mem_ctl});
      compare("busy_oe", 8'h00, {6'h00, busy, mem_data_oe});
      @(posedge clk);
      #1;
      rst_b = 1'b1;
      $display("reset test done");
      start(ROWS[7]);
      req_cmd = CMD_PROGRAM;
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      req_valid = 1'b0;
      finish(ROWS[7]);
      start(ROWS[7]);
      finish(ROWS[7]);
      $display("refusal test done");
      wrap_up();
   end
   // watchdog: all tests need well under 20000 cycles
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
endmodule : testbench
bind uvmc_ctrl uvmc_ctrl_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.clk(clk), .rst_b(rst_b),
   .req_valid(req_valid), .busy(busy), .done(done), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
   .mem_data_oe(mem_data_oe));
